// ---- common/psr_pkg.sv ----
// Constants and types for the command interpreter block
// Contract
// [RULE1] Store command, bank 2: save user variable
// [RULE2] Bank 0 settings saved automatically when modified
// [RULE3] Restore command, bank 2: reload user variable
// [RULE4] Reload all user variables after power-up
// [RULE5] Home search type: 0 start, 1 stop, 2 query
// [RULE6] Home search state machine start, stop, query
// [RULE7] Query returns zero idle, non-zero running
// [RULE8] Set output drives addressed bank 2 line
// [RULE9] Host sends only 0 or 1 value
// [RULE10] Reply status 100 on success
// [RULE11] Nine-byte frame, value most significant first
// [RULE12] Banks: 0 settings, 2 user vars, 3 interrupts
// [RULE13] Checksum is low byte of sum
// [RULE14] Search-active flag set start, cleared stop/done
package psr_pkg;
  localparam logic [7:0] OP_STORE_UV = 8'h0b;
  localparam logic [7:0] OP_RESTORE_UV = 8'h0c;
  localparam logic [7:0] OP_HOME_SEARCH = 8'h0d;
  localparam logic [7:0] OP_SET_OUTPUT = 8'h0e;
  localparam logic [7:0] OP_SET_GLOBAL = 8'h09;
  localparam logic [7:0] BANK_SETTINGS = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  localparam logic [7:0] HS_START = 8'h00;
  localparam logic [7:0] HS_STOP = 8'h01;
  localparam logic [7:0] HS_QUERY = 8'h02;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [3:0] FRAME_LEN = 4'd9;
  localparam int UV_COUNT = 8;
  localparam int SET_COUNT = 8;
  localparam int OUT_COUNT = 2;
  localparam logic [7:0] DEV_ADDR_DEF = 8'h01;
  localparam logic [7:0] HOST_ADDR_DEF = 8'h02;
  localparam logic [31:0] HS_RUNNING_VALUE = 32'h0000_0001;
  typedef enum logic [1:0] {PSR_IDLE, PSR_EXEC, PSR_REPLY} psr_state_type;
endpackage : psr_pkg

// ---- hw/psr_cmd.sv ----
// Command interpreter: frame decode, user store, home search, outputs
`timescale 1ns/100ps
module psr_cmd import psr_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Frame bytes from the host
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  // Reply bytes to the host
  output logic [7:0] tx_byte,
  output logic tx_valid,
  // Home search engine
  input wire logic home_done,
  output logic home_active,
  // Digital outputs
  output logic [OUT_COUNT-1:0] dout
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  function automatic logic [7:0] csum8(input logic [7:0] b [0:7]);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + b[i];
    end
    return s;
  endfunction : csum8

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  psr_state_type state_r, state_nxt;
  logic [7:0] frm_r [0:8];
  logic [7:0] frm_nxt [0:8];
  logic [3:0] cnt_r, cnt_nxt;
  logic [31:0] uv_r [0:UV_COUNT-1];
  logic [31:0] uv_nxt [0:UV_COUNT-1];
  logic [31:0] nv_r [0:UV_COUNT-1];
  logic [31:0] nv_nxt [0:UV_COUNT-1];
  logic [31:0] set_r [0:SET_COUNT-1];
  logic [31:0] set_nxt [0:SET_COUNT-1];
  logic [31:0] setnv_r [0:SET_COUNT-1];
  logic [31:0] setnv_nxt [0:SET_COUNT-1];
  logic [7:0] rep_r [0:8];
  logic [7:0] rep_nxt [0:8];
  logic [7:0] tx_byte_nxt;
  logic tx_valid_nxt, home_nxt, boot_r, boot_nxt;
  logic [OUT_COUNT-1:0] dout_nxt;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] hdr [0:7];
    logic [7:0] st, op, typ, bank;
    logic [31:0] val, rval;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    frm_nxt = frm_r;
    uv_nxt = uv_r;
    nv_nxt = nv_r;
    set_nxt = set_r;
    setnv_nxt = setnv_r;
    rep_nxt = rep_r;
    tx_byte_nxt = 8'h00;
    tx_valid_nxt = 1'b0;
    home_nxt = home_active;
    dout_nxt = dout;
    boot_nxt = 1'b0;
    st = ST_OK;
    rval = 32'h0;
    op = frm_r[1];
    typ = frm_r[2];
    bank = frm_r[3];
    val = {frm_r[4], frm_r[5], frm_r[6], frm_r[7]}; // see [RULE11]
    for (int i = 0; i < 8; i++) begin
      hdr[i] = frm_r[i];
    end
    // Done pulse ends the search; a start in the same cycle wins below
    if (home_done) begin
      home_nxt = 1'b0; // see [RULE14]
    end
    if (boot_r) begin
      uv_nxt = nv_r; // see [RULE4]
    end
    unique case (state_r)
      PSR_IDLE: begin
        if (rx_valid) begin
          frm_nxt[cnt_r] = rx_byte; // see [RULE11]
          if (cnt_r == FRAME_LEN - 4'd1) begin
            cnt_nxt = 4'd0;
            state_nxt = PSR_EXEC;
          end else begin
            cnt_nxt = cnt_r + 4'd1;
          end
        end
      end
      PSR_EXEC: begin
        if (csum8(hdr) != frm_r[8]) begin
          st = ST_BAD_CSUM; // see [RULE13]
        end else begin
          unique case (op)
            OP_STORE_UV: begin
              if (bank == BANK_USER && typ < 8'(UV_COUNT)) begin
                nv_nxt[typ[2:0]] = uv_r[typ[2:0]]; // see [RULE1]
              end else begin
                st = ST_BAD_TYPE; // see [RULE12]
              end
            end
            OP_RESTORE_UV: begin
              if (bank == BANK_USER && typ < 8'(UV_COUNT)) begin
                uv_nxt[typ[2:0]] = nv_r[typ[2:0]]; // see [RULE3]
              end else begin
                st = ST_BAD_TYPE;
              end
            end
            OP_SET_GLOBAL: begin
              if (bank == BANK_USER && typ < 8'(UV_COUNT)) begin
                uv_nxt[typ[2:0]] = val;
              end else if (bank == BANK_SETTINGS && typ < 8'(SET_COUNT)) begin
                set_nxt[typ[2:0]] = val;
                setnv_nxt[typ[2:0]] = val; // see [RULE2]
              end else begin
                st = ST_BAD_TYPE;
              end
            end
            OP_HOME_SEARCH: begin
              if (bank != 8'h00) begin
                st = ST_BAD_VALUE;
              end else if (typ == HS_START) begin
                home_nxt = 1'b1; // see [RULE5] [RULE6] [RULE14]
              end else if (typ == HS_STOP) begin
                home_nxt = 1'b0; // see [RULE6] [RULE14]
              end else if (typ == HS_QUERY) begin
                rval = home_active ? HS_RUNNING_VALUE : 32'h0; // see [RULE7]
              end else begin
                st = ST_BAD_TYPE;
              end
            end
            OP_SET_OUTPUT: begin
              // Values above 1 are refused rather than truncated
              if (bank != BANK_USER || typ >= 8'(OUT_COUNT)) begin
                st = ST_BAD_TYPE;
              end else if (val > 32'h1) begin
                st = ST_BAD_VALUE; // see [RULE9]
              end else begin
                dout_nxt[typ[0]] = val[0]; // see [RULE8]
              end
            end
            default: st = ST_BAD_CMD;
          endcase
        end
        rep_nxt[0] = HOST_ADDR_DEF;
        rep_nxt[1] = frm_r[0];
        rep_nxt[2] = st; // see [RULE10]
        rep_nxt[3] = op;
        rep_nxt[4] = rval[31:24];
        rep_nxt[5] = rval[23:16];
        rep_nxt[6] = rval[15:8];
        rep_nxt[7] = rval[7:0];
        rep_nxt[8] = HOST_ADDR_DEF + frm_r[0] + st + op + rval[31:24]
                     + rval[23:16] + rval[15:8] + rval[7:0]; // see [RULE13]
        state_nxt = PSR_REPLY;
      end
      PSR_REPLY: begin
        tx_valid_nxt = 1'b1;
        tx_byte_nxt = rep_r[cnt_r];
        if (cnt_r == FRAME_LEN - 4'd1) begin
          cnt_nxt = 4'd0;
          state_nxt = PSR_IDLE;
        end else begin
          cnt_nxt = cnt_r + 4'd1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Non-volatile copies live in their own reset-free process below,
  // so a reset behaves like a power cycle and reloads user variables.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PSR_IDLE;
      cnt_r <= 4'd0;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      home_active <= 1'b0;
      dout <= '0;
      boot_r <= 1'b1;
      for (int i = 0; i < 9; i++) begin
        frm_r[i] <= 8'h00;
        rep_r[i] <= 8'h00;
      end
      for (int i = 0; i < UV_COUNT; i++) begin
        uv_r[i] <= 32'h0;
      end
      for (int i = 0; i < SET_COUNT; i++) begin
        set_r[i] <= 32'h0;
      end
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      tx_byte <= tx_byte_nxt;
      tx_valid <= tx_valid_nxt;
      home_active <= home_nxt;
      dout <= dout_nxt;
      boot_r <= boot_nxt;
      frm_r <= frm_nxt;
      rep_r <= rep_nxt;
      uv_r <= uv_nxt;
      set_r <= set_nxt;
    end
  end

  // Stored copies survive reset; their power-on contents are undefined
  always_ff @(posedge clk) begin
    nv_r <= nv_nxt; // see [RULE4]
    setnv_r <= setnv_nxt;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reply_len: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE11]
    $rose(tx_valid) |=> tx_valid [*8] ##1 !tx_valid)
    else $error("reply is not nine bytes");
  a_store_copy: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE1]
    (state_r == PSR_EXEC && op_ok(OP_STORE_UV)) |=> nv_r[$past(frm_r[2][2:0])] ==
      $past(uv_r[frm_r[2][2:0]]))
    else $error("store did not copy user variable");
  a_restore_copy: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE3]
    (state_r == PSR_EXEC && op_ok(OP_RESTORE_UV)) |=> uv_r[$past(frm_r[2][2:0])] ==
      $past(nv_r[frm_r[2][2:0]]))
    else $error("restore did not reload user variable");
  a_home_start: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE14]
    (state_r == PSR_EXEC && op_ok(OP_HOME_SEARCH) && frm_r[2] == HS_START) |=> home_active)
    else $error("start did not set search flag");
  a_home_stop: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE6]
    (state_r == PSR_EXEC && op_ok(OP_HOME_SEARCH) && frm_r[2] == HS_STOP) |=> !home_active)
    else $error("stop did not clear search flag");
  a_query_val: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE7]
    (state_r == PSR_EXEC && op_ok(OP_HOME_SEARCH) && frm_r[2] == HS_QUERY)
      |=> ((rep_r[7] != 8'h00) == $past(home_active)))
    else $error("query value wrong");
  a_out_set: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE8]
    (state_r == PSR_EXEC && op_ok(OP_SET_OUTPUT) && frm_r[2] < 8'(OUT_COUNT)
      && frm_r[7] <= 8'h01 && {frm_r[4], frm_r[5], frm_r[6]} == 24'h00_0000)
      |=> dout[$past(frm_r[2][0])] == $past(frm_r[7][0]))
    else $error("output not driven");
  a_ok_status: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
    (state_r == PSR_EXEC && op_ok(OP_STORE_UV)) |=> rep_r[2] == ST_OK ##3 tx_byte == ST_OK)
    else $error("status not OK");

  function automatic logic op_ok(input logic [7:0] o);
    logic [7:0] h [0:7];
    for (int i = 0; i < 8; i++) begin
      h[i] = frm_r[i];
    end
    return frm_r[1] == o && csum8(h) == frm_r[8]
      && (o == OP_HOME_SEARCH ? frm_r[3] == 8'h00 : frm_r[3] == BANK_USER)
      && (o == OP_HOME_SEARCH || frm_r[2] < 8'(UV_COUNT));
  endfunction : op_ok
endmodule : psr_cmd

// ---- test/psr_host.sv ----
// Host model: sends command frames and gathers the reply
`timescale 1ns/100ps
module psr_host import psr_pkg::*; (
  // Clock
  input wire logic clk,
  // Frame bytes to the block
  output logic [7:0] rx_byte,
  output logic rx_valid,
  // Reply bytes from the block
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid
);
  logic [7:0] rep [9];
  logic got;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    got = 1'b0;
  end
  task automatic xfer(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bank,
      input logic [31:0] val, input logic bad);
    logic [7:0] f [9];
    f = '{DEV_ADDR_DEF, op, ty, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] = f[8] ^ {7'h00, bad};
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_byte = f[i];
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    // Released line shows the inverse so a stale byte is never mistaken for data
    rx_byte = ~f[8];
    for (int n = 0; n < 40 && tx_valid !== 1'b1; n++) @(negedge clk);
    got = (tx_valid === 1'b1);
    for (int i = 0; i < 9; i++) begin
      rep[i] = tx_byte;
      @(negedge clk);
    end
  endtask : xfer
endmodule : psr_host

// ---- test/psr_cmd_test.sv ----
// Self-checking testbench for the command interpreter
`timescale 1ns/100ps
module psr_cmd_test import psr_pkg::*;;
  logic clk;
  logic rst_b;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic home_done;
  logic home_active;
  logic [OUT_COUNT-1:0] dout;
  logic [31:0] rv;
  int fails;
  int checked;
  psr_cmd psr_cmd_inst (.clk(clk), .rst_b(rst_b), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .home_done(home_done),
    .home_active(home_active), .dout(dout));
  psr_host psr_host_inst (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic do_reset();
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset
  // Every reply is framed and checksummed alike; status and echo checked here
  task automatic cmd(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bank,
      input logic [31:0] val, input logic bad, input logic [7:0] st);
    logic [7:0] s;
    psr_host_inst.xfer(op, ty, bank, val, bad);
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += psr_host_inst.rep[i];
    rv = {psr_host_inst.rep[4], psr_host_inst.rep[5], psr_host_inst.rep[6], psr_host_inst.rep[7]};
    chk(32'(psr_host_inst.got), 32'h1);
    chk(32'(psr_host_inst.rep[0]), 32'(HOST_ADDR_DEF));
    chk(32'(psr_host_inst.rep[1]), 32'(DEV_ADDR_DEF));
    chk(32'(psr_host_inst.rep[2]), 32'(st));
    chk(32'(psr_host_inst.rep[3]), 32'(op));
    chk(32'(psr_host_inst.rep[8]), 32'(s));
  endtask : cmd
  task automatic test_output();
    cmd(OP_SET_OUTPUT, 8'h00, BANK_USER, 32'h1, 1'b0, ST_OK);
    cmd(OP_SET_OUTPUT, 8'h01, BANK_USER, 32'h1, 1'b0, ST_OK);
    chk(32'(dout), 32'h3);
    cmd(OP_SET_OUTPUT, 8'h00, BANK_USER, 32'h0, 1'b0, ST_OK);
    chk(32'(dout), 32'h2);
    cmd(OP_SET_OUTPUT, 8'h00, BANK_SETTINGS, 32'h1, 1'b0, ST_BAD_TYPE);
    cmd(OP_SET_OUTPUT, 8'h00, BANK_USER, 32'h2, 1'b0, ST_BAD_VALUE);
    chk(32'(dout), 32'h2);
    $display("test_output done");
  endtask : test_output
  task automatic test_home();
    cmd(OP_HOME_SEARCH, HS_QUERY, 8'h00, 32'h0, 1'b0, ST_OK);
    chk(rv, 32'h0);
    cmd(OP_HOME_SEARCH, HS_START, 8'h00, 32'h0, 1'b0, ST_OK);
    chk(32'(home_active), 32'h1);
    cmd(OP_HOME_SEARCH, HS_QUERY, 8'h00, 32'h0, 1'b0, ST_OK);
    chk(32'(rv != 32'h0), 32'h1);
    cmd(OP_HOME_SEARCH, HS_STOP, 8'h00, 32'h0, 1'b0, ST_OK);
    chk(32'(home_active), 32'h0);
    cmd(OP_HOME_SEARCH, HS_START, 8'h00, 32'h0, 1'b0, ST_OK);
    @(posedge clk);
    #1;
    home_done = 1'b1;
    @(posedge clk);
    #1;
    home_done = 1'b0;
    @(negedge clk);
    chk(32'(home_active), 32'h0);
    cmd(OP_HOME_SEARCH, 8'h03, 8'h00, 32'h0, 1'b0, ST_BAD_TYPE);
    cmd(OP_HOME_SEARCH, HS_START, 8'h01, 32'h0, 1'b0, ST_BAD_VALUE);
    chk(32'(home_active), 32'h0);
    $display("test_home done");
  endtask : test_home
  task automatic test_store();
    cmd(OP_SET_GLOBAL, 8'h07, BANK_USER, 32'h1234_5678, 1'b0, ST_OK);
    cmd(OP_STORE_UV, 8'h07, BANK_USER, 32'hffff_ffff, 1'b0, ST_OK);
    chk(psr_cmd_inst.nv_r[7], 32'h1234_5678);
    cmd(OP_SET_GLOBAL, 8'h07, BANK_USER, 32'h0bad_cafe, 1'b0, ST_OK);
    cmd(OP_RESTORE_UV, 8'h07, BANK_USER, 32'h0, 1'b0, ST_OK);
    chk(psr_cmd_inst.uv_r[7], 32'h1234_5678);
    cmd(OP_STORE_UV, 8'h07, BANK_SETTINGS, 32'h0, 1'b0, ST_BAD_TYPE);
    cmd(OP_SET_GLOBAL, 8'h00, BANK_SETTINGS, 32'h5, 1'b0, ST_OK);
    chk(psr_cmd_inst.setnv_r[0], 32'h5);
    cmd(8'h3f, 8'h00, 8'h00, 32'h0, 1'b0, ST_BAD_CMD);
    cmd(OP_SET_OUTPUT, 8'h01, BANK_USER, 32'h0, 1'b1, ST_BAD_CSUM);
    chk(32'(dout), 32'h2);
    $display("test_store done");
  endtask : test_store
  task automatic test_reset();
    cmd(OP_SET_GLOBAL, 8'h07, BANK_USER, 32'h0bad_cafe, 1'b0, ST_OK);
    cmd(OP_HOME_SEARCH, HS_START, 8'h00, 32'h0, 1'b0, ST_OK);
    do_reset();
    chk(32'({home_active, dout}), 32'h0);
    chk(psr_cmd_inst.uv_r[7], 32'h1234_5678);
    cmd(OP_HOME_SEARCH, HS_QUERY, 8'h00, 32'h0, 1'b0, ST_OK);
    chk(rv, 32'h0);
    $display("test_reset done");
  endtask : test_reset
  initial begin
    rst_b = 1'b0;
    home_done = 1'b0;
    fails = 0;
    checked = 0;
    rv = 32'h0;
    do_reset();
    test_output();
    test_home();
    test_store();
    test_reset();
    final_report();
  end
  // Tests need some 500 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : psr_cmd_test
